// ---- mas_pkg.sv ----
// Package with register map, field layout, strap bundles and state codes for the media and negotiation loader
// Functional notes
// - Receive-error pin sampled at reset: floating selects twisted pair, pulled low selects fiber.
// - Fiber strap presets far-end fault enable, scrambler bypass and descrambler bypass bits.
// - Writing fiber enable, bit 6 of coding-sublayer control, switches the media.
// - Negotiation strap low forces mode: speed strap 0/1 = 10/100, duplex 0/1 = half/full.
// - Negotiation strap high advertises per speed/duplex straps: 00,01,10,11 ability sets.
// - Advertisement ability bits [8:5] are loaded from the sampled strap states.
// - Writes to basic mode control override strapped negotiation settings once the strap load is done; a write in the load cycle is lost.
// - Negotiation picks highest-performance mode common to both ends from partner abilities.
// - Priority is 100 full, 100 half, 10 full, 10 half.
// - Speed and duplex control bits act only while negotiation is disabled.
// - The advertisement register contents are the abilities offered during negotiation.
package mas_pkg;

    // Printed register indices; the APB byte address is four times the index
    localparam logic [7:0] MAS_IDX_BASIC_MODE_CONTROL   = 8'h00;
    localparam logic [7:0] MAS_IDX_ADVERTISEMENT        = 8'h04;
    localparam logic [7:0] MAS_IDX_CODING_SUBLAYER_CTRL = 8'h16;
    localparam logic [7:0] MAS_IDX_MODE_STATUS          = 8'h1F;
    localparam int         MAS_ADDR_WIDTH               = 10;

    // Basic mode control fields
    localparam int MAS_BMC_SPEED_BIT   = 13;
    localparam int MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT   = 12;
    localparam int MAS_BMC_RESTART_BIT = 9;
    localparam int MAS_BMC_DUPLEX_BIT  = 8;

    // Advertisement fields
    localparam int          MAS_ADV_ABILITY_LSB = 5;
    localparam logic [4:0]  MAS_ADV_SELECTOR    = 5'h01;
    localparam logic [3:0]  MAS_ABL_10_HALF     = 4'h1;
    localparam logic [3:0]  MAS_ABL_10_FULL     = 4'h2;
    localparam logic [3:0]  MAS_ABL_100_HALF    = 4'h4;
    localparam logic [3:0]  MAS_ABL_100_FULL    = 4'h8;

    // Coding-sublayer control fields
    localparam int MAS_CSC_FIBER_BIT      = 6;
    localparam int MAS_CSC_FAR_FAULT_BIT  = 3;
    localparam int MAS_CSC_SCR_BYPASS_BIT = 1;
    localparam int MAS_CSC_DSC_BYPASS_BIT = 0;

    // Mode status fields
    localparam int MAS_STS_VALID_BIT  = 4;
    localparam int MAS_STS_ACTIVE_BIT = 3;
    localparam int MAS_STS_SPEED_BIT  = 2;
    localparam int MAS_STS_DUPLEX_BIT = 1;
    localparam int MAS_STS_FIBER_BIT  = 0;

    localparam logic [15:0] MAS_REG_RESET = 16'h0000;

    typedef struct packed {
        logic fiber;
        logic an_enable;
        logic speed;
        logic duplex;
    } mas_strap_type;

    typedef struct packed {
        logic valid;
        logic speed_100;
        logic full_duplex;
    } mas_mode_type;

    typedef enum logic [1:0] {
        MAS_LOAD_WAIT = 2'b00,
        MAS_LOAD_FIRE = 2'b01,
        MAS_LOAD_HELD = 2'b10
    } mas_load_state_type;

endpackage

// ---- mas_strap_capture.sv ----
// Strap sampler that latches the pin levels once after reset release
`timescale 1ns/10ps
module mas_strap_capture
    import mas_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire mas_strap_type pins,
    output mas_strap_type      held,
    output logic               load
);

    mas_load_state_type state;

    // Pins are sampled at the first edge after release, never under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MAS_LOAD_WAIT;
            held  <= '0;
            load  <= 1'b0;
        end else begin
            case (state)
                MAS_LOAD_WAIT: begin
                    held  <= pins;
                    load  <= 1'b1;
                    state <= MAS_LOAD_FIRE;
                end
                MAS_LOAD_FIRE: begin
                    load  <= 1'b0;
                    state <= MAS_LOAD_HELD;
                end
                MAS_LOAD_HELD: begin
                    load <= 1'b0;
                end
                default: begin
                    load  <= 1'b0;
                    state <= MAS_LOAD_HELD;
                end
            endcase
        end
    end

endmodule // mas_strap_capture

// ---- mas_resolve.sv ----
// Priority resolver for the common negotiated mode
`timescale 1ns/10ps
module mas_resolve
    import mas_pkg::*;
(
    input  wire logic [3:0] local_ability,
    input  wire logic [3:0] partner_ability,
    output mas_mode_type    mode
);

    logic [3:0] common;

    always_comb begin
        common = local_ability & partner_ability;
        mode   = '0;
        if ((common & MAS_ABL_100_FULL) != 4'h0) begin
            mode = '{valid: 1'b1, speed_100: 1'b1, full_duplex: 1'b1};
        end else if ((common & MAS_ABL_100_HALF) != 4'h0) begin
            mode = '{valid: 1'b1, speed_100: 1'b1, full_duplex: 1'b0};
        end else if ((common & MAS_ABL_10_FULL) != 4'h0) begin
            mode = '{valid: 1'b1, speed_100: 1'b0, full_duplex: 1'b1};
        end else if ((common & MAS_ABL_10_HALF) != 4'h0) begin
            mode = '{valid: 1'b1, speed_100: 1'b0, full_duplex: 1'b0};
        end
    end

endmodule // mas_resolve

// ---- mas_top.sv ----
// Strap-driven media and negotiation configuration with an APB register file
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module mas_top
    import mas_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [MAS_ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      receive_error_strap,
    input  wire logic                      negotiation_enable_strap,
    input  wire logic                      speed_ability_strap,
    input  wire logic                      duplex_ability_strap,
    input  wire logic [3:0]                partner_ability,
    input  wire logic                      partner_ability_valid,
    output logic                           fiber_media_enable,
    output logic                           far_end_fault_enable,
    output logic                           scrambler_bypass,
    output logic                           descrambler_bypass,
    output logic [3:0]                     advertised_ability,
    output logic                           negotiation_active,
    output logic                           negotiation_restart,
    output logic                           link_speed_100,
    output logic                           link_full_duplex,
    output logic                           link_mode_valid
);

    mas_strap_type strap_pins;
    mas_strap_type strap;
    logic          strap_load;
    mas_mode_type  resolved;

    logic [15:0]   basic_mode_control;
    logic [15:0]   advertisement_register;
    logic [15:0]   coding_sublayer_control;
    logic          negotiation_armed;

    logic          access;
    logic          wr_done;
    logic          hit_bmc;
    logic          hit_adv;
    logic          hit_csc;
    logic          hit_sts;
    logic          mapped;
    logic [31:0]   read_word;
    logic [3:0]    strap_ability;
    logic [15:0]   strap_bmc;
    logic          next_speed;
    logic          next_duplex;
    logic          next_valid;

    // Pull-low on the receive-error pin means fiber; a floating pin reads high
    always_comb begin
        strap_pins.fiber     = ~receive_error_strap;
        strap_pins.an_enable = negotiation_enable_strap;
        strap_pins.speed     = speed_ability_strap;
        strap_pins.duplex    = duplex_ability_strap;
    end

    mas_strap_capture u_capture (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (strap_pins),
        .held    (strap),
        .load    (strap_load)
    );

    mas_resolve u_resolve (
        .local_ability   (advertisement_register[MAS_ADV_ABILITY_LSB +: 4]),
        .partner_ability (partner_ability & {4{partner_ability_valid}}),
        .mode            (resolved)
    );

    // Ability set and control word implied by the captured straps
    always_comb begin
        strap_ability = 4'h0;
        if (strap.an_enable) begin
            case ({strap.speed, strap.duplex})
                2'b00:   strap_ability = MAS_ABL_10_HALF | MAS_ABL_10_FULL;
                2'b01:   strap_ability = MAS_ABL_100_HALF | MAS_ABL_100_FULL;
                2'b10:   strap_ability = MAS_ABL_100_FULL;
                2'b11:   strap_ability = MAS_ABL_10_HALF | MAS_ABL_10_FULL | MAS_ABL_100_HALF | MAS_ABL_100_FULL;
                default: strap_ability = 4'h0;
            endcase
        end else begin
            // A forced port advertises only the mode it is forced into
            case ({strap.speed, strap.duplex})
                2'b00:   strap_ability = MAS_ABL_10_HALF;
                2'b01:   strap_ability = MAS_ABL_10_FULL;
                2'b10:   strap_ability = MAS_ABL_100_HALF;
                2'b11:   strap_ability = MAS_ABL_100_FULL;
                default: strap_ability = 4'h0;
            endcase
        end
        strap_bmc                      = MAS_REG_RESET;
        strap_bmc[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT]   = strap.an_enable;
        strap_bmc[MAS_BMC_SPEED_BIT]   = strap.speed;
        strap_bmc[MAS_BMC_DUPLEX_BIT]  = strap.duplex;
    end

    // APB decode; one wait state so that read data and pready both leave flops
    always_comb begin
        access  = psel & penable;
        wr_done = access & pready & pwrite;
        hit_bmc = (paddr == {MAS_IDX_BASIC_MODE_CONTROL, 2'b00});
        hit_adv = (paddr == {MAS_IDX_ADVERTISEMENT, 2'b00});
        hit_csc = (paddr == {MAS_IDX_CODING_SUBLAYER_CTRL, 2'b00});
        hit_sts = (paddr == {MAS_IDX_MODE_STATUS, 2'b00});
        mapped  = hit_bmc | hit_adv | hit_csc | hit_sts;
    end

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_bmc) begin
            read_word[15:0] = basic_mode_control;
        end else if (hit_adv) begin
            read_word[15:0] = advertisement_register;
        end else if (hit_csc) begin
            read_word[15:0] = coding_sublayer_control;
        end else if (hit_sts) begin
            read_word[MAS_STS_VALID_BIT]  = link_mode_valid;
            read_word[MAS_STS_ACTIVE_BIT] = negotiation_active;
            read_word[MAS_STS_SPEED_BIT]  = link_speed_100;
            read_word[MAS_STS_DUPLEX_BIT] = link_full_duplex;
            read_word[MAS_STS_FIBER_BIT]  = fiber_media_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite) begin
                prdata <= read_word;
            end
        end
    end

    // Basic mode control: strap load first, software writes override later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            basic_mode_control <= MAS_REG_RESET;
        end else if (strap_load) begin
            basic_mode_control <= strap_bmc;
        end else if (wr_done & hit_bmc) begin
            basic_mode_control                      <= pwdata[15:0];
            basic_mode_control[MAS_BMC_RESTART_BIT] <= 1'b0;
        end
    end

    // Restart is a self-clearing command; it shows only as a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            negotiation_restart <= 1'b0;
        end else begin
            negotiation_restart <= wr_done & hit_bmc & pwdata[MAS_BMC_RESTART_BIT] & pwdata[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT];
        end
    end

    // A forced start keeps negotiation off until enable sees a clear-to-set edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            negotiation_armed <= 1'b0;
        end else if (strap_load) begin
            negotiation_armed <= strap.an_enable;
        end else if (wr_done & hit_bmc & pwdata[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT] & ~basic_mode_control[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT]) begin
            negotiation_armed <= 1'b1;
        end
    end

    // Advertisement register; its ability field is what the link engine sends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advertisement_register <= MAS_REG_RESET;
        end else if (strap_load) begin
            advertisement_register                           <= {11'h000, MAS_ADV_SELECTOR};
            advertisement_register[MAS_ADV_ABILITY_LSB +: 4] <= strap_ability;
        end else if (wr_done & hit_adv) begin
            advertisement_register <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advertised_ability <= 4'h0;
        end else begin
            advertised_ability <= advertisement_register[MAS_ADV_ABILITY_LSB +: 4];
        end
    end

    // Coding-sublayer control; a fiber strap presets the fiber support bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coding_sublayer_control <= MAS_REG_RESET;
        end else if (strap_load) begin
            coding_sublayer_control                         <= MAS_REG_RESET;
            coding_sublayer_control[MAS_CSC_FIBER_BIT]      <= strap.fiber;
            coding_sublayer_control[MAS_CSC_FAR_FAULT_BIT]  <= strap.fiber;
            coding_sublayer_control[MAS_CSC_SCR_BYPASS_BIT] <= strap.fiber;
            coding_sublayer_control[MAS_CSC_DSC_BYPASS_BIT] <= strap.fiber;
        end else if (wr_done & hit_csc) begin
            coding_sublayer_control <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fiber_media_enable   <= 1'b0;
            far_end_fault_enable <= 1'b0;
            scrambler_bypass     <= 1'b0;
            descrambler_bypass   <= 1'b0;
        end else begin
            fiber_media_enable   <= coding_sublayer_control[MAS_CSC_FIBER_BIT];
            far_end_fault_enable <= coding_sublayer_control[MAS_CSC_FAR_FAULT_BIT];
            scrambler_bypass     <= coding_sublayer_control[MAS_CSC_SCR_BYPASS_BIT];
            descrambler_bypass   <= coding_sublayer_control[MAS_CSC_DSC_BYPASS_BIT];
        end
    end

    // Operating mode: resolved while negotiating, control bits otherwise
    always_comb begin
        if (basic_mode_control[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT] & negotiation_armed) begin
            next_speed  = resolved.speed_100;
            next_duplex = resolved.full_duplex;
            next_valid  = partner_ability_valid & resolved.valid;
        end else begin
            next_speed  = basic_mode_control[MAS_BMC_SPEED_BIT];
            next_duplex = basic_mode_control[MAS_BMC_DUPLEX_BIT];
            next_valid  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            negotiation_active <= 1'b0;
            link_speed_100     <= 1'b0;
            link_full_duplex   <= 1'b0;
            link_mode_valid    <= 1'b0;
        end else begin
            negotiation_active <= basic_mode_control[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT] & negotiation_armed;
            link_speed_100     <= next_speed;
            link_full_duplex   <= next_duplex;
            link_mode_valid    <= next_valid;
        end
    end

endmodule // mas_top

// ---- mas_top_monitor.sv ----
// Concurrent checks on the register bus and configuration outputs of the loader
`timescale 1ns/10ps
module mas_top_monitor
    import mas_pkg::*;
(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [MAS_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic [3:0]                partner_ability,
    input wire logic                      partner_ability_valid,
    input wire logic                      fiber_media_enable,
    input wire logic                      far_end_fault_enable,
    input wire logic                      scrambler_bypass,
    input wire logic                      descrambler_bypass,
    input wire logic [3:0]                advertised_ability,
    input wire logic                      negotiation_active,
    input wire logic                      negotiation_restart,
    input wire logic                      link_speed_100,
    input wire logic                      link_full_duplex,
    input wire logic                      link_mode_valid
);
    wire logic       wr_done  = psel && penable && pready && pwrite;
    wire logic       bmc_wr   = wr_done && paddr == {MAS_IDX_BASIC_MODE_CONTROL, 2'b00};
    wire logic       adv_wr   = wr_done && paddr == {MAS_IDX_ADVERTISEMENT, 2'b00};
    wire logic       csc_wr   = wr_done && paddr == {MAS_IDX_CODING_SUBLAYER_CTRL, 2'b00};
    wire logic       mapped   = paddr == {MAS_IDX_BASIC_MODE_CONTROL, 2'b00} || paddr == {MAS_IDX_ADVERTISEMENT, 2'b00}
                                || paddr == {MAS_IDX_CODING_SUBLAYER_CTRL, 2'b00} || paddr == {MAS_IDX_MODE_STATUS, 2'b00};
    wire logic [1:0] bmc_sd   = {pwdata[MAS_BMC_SPEED_BIT], pwdata[MAS_BMC_DUPLEX_BIT]};
    wire logic [3:0] csc_bits = {pwdata[6], pwdata[3], pwdata[1:0]};
    wire logic [3:0] adv_bits = pwdata[8:5];
    wire logic [3:0] common   = advertised_ability & partner_ability;
    wire logic [3:0] media    = {fiber_media_enable, far_end_fault_enable, scrambler_bypass, descrambler_bypass};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    ready_after_wait_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside the second access cycle");
    err_on_unmapped_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    forced_mode_follow_a: assert property (bmc_wr && !pwdata[MAS_BMC_NEGOTIATION_ENABLE_STRAP_BIT] |-> ##2
        (link_mode_valid && {link_speed_100, link_full_duplex} == $past(bmc_sd, 2)))
        else $error("forced mode does not follow the control write");
    media_write_follow_a: assert property (csc_wr |-> ##2 media == $past(csc_bits, 2))
        else $error("media bits do not follow the sublayer write");
    advert_write_follow_a: assert property (adv_wr |-> ##2 advertised_ability == $past(adv_bits, 2))
        else $error("advertised abilities do not follow the write");
    priority_resolve_a: assert property ((negotiation_active && partner_ability_valid && $stable(partner_ability)
        && $stable(advertised_ability))[*4] |-> link_mode_valid == (|common) && link_speed_100 == (|common[3:2])
        && link_full_duplex == (common[3] || (!common[2] && common[1])))
        else $error("resolved mode is not the best common one");
    restart_cause_a: assert property (bmc_wr && pwdata[9] && pwdata[12] |-> ##[1:3] negotiation_restart)
        else $error("restart write gave no restart pulse");
    restart_pulse_a: assert property (negotiation_restart |=> !negotiation_restart)
        else $error("restart pulse longer than one cycle");

    refused_c: cover property (pready && pslverr);
    restart_c: cover property (negotiation_restart);
    negotiated_c: cover property (negotiation_active && link_mode_valid);
endmodule // mas_top_monitor

bind mas_top mas_top_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .partner_ability, .partner_ability_valid, .fiber_media_enable, .far_end_fault_enable, .scrambler_bypass,
    .descrambler_bypass, .advertised_ability, .negotiation_active, .negotiation_restart, .link_speed_100,
    .link_full_duplex, .link_mode_valid);

// ---- mas_strap_board.sv ----
// Board strap resistors and link partner abilities facing the loader
`timescale 1ns/10ps
module mas_strap_board
    import mas_pkg::*;
(
    input  wire logic          pclk,
    input  wire mas_strap_type cfg,
    input  wire logic [3:0]    abilities,
    input  wire logic          abilities_on,
    output logic               receive_error_strap,
    output logic               negotiation_enable_strap,
    output logic               speed_ability_strap,
    output logic               duplex_ability_strap,
    output logic [3:0]         partner_ability,
    output logic               partner_ability_valid
);
    logic [3:0] idle_pattern = 4'h5;
    // Receive-error line floats high; only a pulldown picks fiber
    assign receive_error_strap      = !cfg.fiber;
    assign negotiation_enable_strap = cfg.an_enable;
    assign speed_ability_strap      = cfg.speed;
    assign duplex_ability_strap     = cfg.duplex;
    // An absent partner leaves the lines toggling so a stale value never looks usable
    always @(posedge pclk) idle_pattern <= ~idle_pattern;
    assign partner_ability       = abilities_on ? abilities : idle_pattern;
    assign partner_ability_valid = abilities_on;
endmodule // mas_strap_board

// ---- mas_top_tb_top.sv ----
// Self-checking bench for the strap and negotiation loader
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin failures++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module mas_top_tb_top
    import mas_pkg::*;
;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, abl_on = 1'b0;
    logic [9:0]    paddr = 10'h000;
    logic [31:0]   pwdata = 32'h0, prdata, rd, rnd;
    logic          pready, pslverr, err, seen;
    mas_strap_type cfg = 4'h0, s;
    logic [3:0]    abl = 4'h0, adv, advertised_ability, partner_ability;
    logic          receive_error_strap, negotiation_enable_strap, speed_ability_strap, duplex_ability_strap;
    logic          fiber_media_enable, far_end_fault_enable, scrambler_bypass, descrambler_bypass;
    logic          partner_ability_valid, negotiation_active, negotiation_restart;
    logic          link_speed_100, link_full_duplex, link_mode_valid;
    integer        failures = 0, samples_checked = 0, seed = 15, i, k;
    wire  [2:0]    mode  = {link_mode_valid, link_speed_100, link_full_duplex};
    wire  [3:0]    media = {fiber_media_enable, far_end_fault_enable, scrambler_bypass, descrambler_bypass};

    mas_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .receive_error_strap, .negotiation_enable_strap, .speed_ability_strap, .duplex_ability_strap,
        .partner_ability, .partner_ability_valid, .fiber_media_enable, .far_end_fault_enable, .scrambler_bypass,
        .descrambler_bypass, .advertised_ability, .negotiation_active, .negotiation_restart, .link_speed_100,
        .link_full_duplex, .link_mode_valid);
    mas_strap_board board (.pclk, .cfg, .abilities(abl), .abilities_on(abl_on), .receive_error_strap,
        .negotiation_enable_strap, .speed_ability_strap, .duplex_ability_strap, .partner_ability,
        .partner_ability_valid);

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        tick(6);
        presetn <= 1'b1;
        tick(5);
    endtask

    // Waits for pready and takes data and response at that same edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) begin
            failures++;
            finish_test();
        end
    endtask

    function automatic logic [3:0] exp_adv(input mas_strap_type t);
        if (!t.an_enable) return t.speed ? (t.duplex ? MAS_ABL_100_FULL : MAS_ABL_100_HALF)
                                         : (t.duplex ? MAS_ABL_10_FULL : MAS_ABL_10_HALF);
        case ({t.speed, t.duplex})
            2'b00: return MAS_ABL_10_HALF | MAS_ABL_10_FULL;
            2'b01: return MAS_ABL_100_HALF | MAS_ABL_100_FULL;
            2'b10: return MAS_ABL_100_FULL;
            default: return 4'hF;
        endcase
    endfunction

    // Best common mode as {valid, speed_100, full_duplex}
    function automatic logic [2:0] exp_mode(input logic [3:0] c);
        if (c[3]) return 3'b111;
        if (c[2]) return 3'b110;
        if (c[1]) return 3'b101;
        if (c[0]) return 3'b100;
        return 3'b000;
    endfunction

    initial begin
        for (i = 0; i < 16; i++) begin
            rnd = $random(seed);
            cfg <= mas_strap_type'(i[3:0]);
            abl <= rnd[3:0];
            abl_on <= 1'b1;
            do_reset();
            s = cfg;
            adv = exp_adv(s);
            `CHK("advert", adv, advertised_ability)
            `CHK("media", {4{s.fiber}}, media)
            apb(1'b0, 10'h010, 32'h0);
            `CHK("advert reg", {23'h0, adv, MAS_ADV_SELECTOR}, rd)
            apb(1'b0, 10'h058, 32'h0);
            `CHK("sublayer reg", s.fiber ? 32'h0000_004B : 32'h0, rd)
            `CHK("mode", s.an_enable ? exp_mode(adv & abl) : {1'b1, s.speed, s.duplex}, mode)
            cfg <= ~s;
            tick(4);
            `CHK("held advert", adv, advertised_ability)
            `CHK("held media", {4{s.fiber}}, media)
        end
        // Software advertisement against random partners; control speed bits must not matter
        cfg <= 4'h7;
        do_reset();
        for (k = 0; k < 24; k++) begin
            rnd = $random(seed);
            adv = (k == 0) ? 4'hF : rnd[3:0];
            abl <= (k == 0) ? 4'h0 : rnd[7:4];
            abl_on <= (k != 3);
            apb(1'b1, 10'h010, {23'h0, adv, MAS_ADV_SELECTOR});
            apb(1'b1, 10'h000, {18'h0, rnd[8], 1'b1, 3'h0, rnd[9], 8'h00});
            tick(4);
            `CHK("advert out", adv, advertised_ability)
            `CHK("negotiated", abl_on ? exp_mode(adv & abl) : 3'b000, mode)
        end
        // Forced start, software forcing, then clear-and-set of the enable
        cfg <= 4'h0;
        abl <= 4'h3;
        abl_on <= 1'b1;
        do_reset();
        `CHK("active forced", 1'b0, negotiation_active)
        for (k = 0; k < 4; k++) begin
            apb(1'b1, 10'h000, {18'h0, k[1], 1'b0, 3'h0, k[0], 8'h00});
            tick(3);
            `CHK("forced write", {1'b1, k[1], k[0]}, mode)
            apb(1'b0, 10'h000, 32'h0);
            `CHK("control reg", {18'h0, k[1], 1'b0, 3'h0, k[0], 8'h00}, rd)
        end
        apb(1'b1, 10'h000, 32'h0000_1000);
        tick(3);
        `CHK("active set", 1'b1, negotiation_active)
        apb(1'b1, 10'h07C, 32'h0000_001F);
        apb(1'b0, 10'h07C, 32'h0);
        `CHK("status", 32'h0000_0018, rd)
        apb(1'b1, 10'h000, 32'h0000_1200);
        seen = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            seen = seen | negotiation_restart;
        end
        `CHK("restart", 1'b1, seen)
        apb(1'b1, 10'h058, 32'h0000_0040);
        tick(3);
        `CHK("fiber by write", 4'h8, media)
        apb(1'b1, 10'h058, 32'h0000_000B);
        tick(3);
        `CHK("twisted by write", 4'h7, media)
        apb(1'b0, 10'h020, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        finish_test();
    end
endmodule // mas_top_tb_top
